/* File: logic/fcd_defines.svh */
// Register map, mode bit positions, operation codes and reset values of the DMA controller
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

`define FCD_NUM_CH 4
`define FCD_CNT_BITS 14
`define FCD_CNT_MSB 13
`define FCD_OP_MSB 15
`define FCD_OP_LSB 14
`define FCD_OP_VERIFY 2'h0
`define FCD_OP_WRITE 2'h1
`define FCD_OP_READ 2'h2
`define FCD_OP_ILLEGAL 2'h3
`define FCD_SEL_GROUP_BIT 3
`define FCD_SEL_CH_MSB 2
`define FCD_SEL_CH_LSB 1
`define FCD_SEL_REG_BIT 0
`define FCD_REG_MODE_STATUS 4'h8
`define FCD_MODE_ROTATE 4
`define FCD_MODE_EXT_WRITE 5
`define FCD_MODE_TC_STOP 6
`define FCD_MODE_AUTO_LOAD 7
`define FCD_MODE_RESET 8'h00
`define FCD_STATUS_RESET 4'h0
`define FCD_WORD_RESET 16'h0000
`define FCD_CNT_ZERO 14'h0000
`define FCD_CNT_STEP 14'h0001
`define FCD_ADDR_STEP 16'h0001
`define FCD_CH_ZERO 2'h0
`define FCD_CH_STEP 2'h1
`define FCD_GRANT_IDLE 4'hf
`define FCD_BYTE_ZERO 8'h00
`define FCD_NIB_ZERO 4'h0

`endif

/* File: logic/fcd_pkg.sv */
// Types shared by the DMA controller
package fcd_pkg;
	typedef enum logic [2:0] {
		FCD_ST_IDLE,
		FCD_ST_HOLD,
		FCD_ST_ADDR,
		FCD_ST_XFER,
		FCD_ST_END
	} fcd_state_e;

	typedef enum logic [1:0] {
		FCD_SEL_NONE,
		FCD_SEL_ADDR,
		FCD_SEL_COUNT,
		FCD_SEL_MODE
	} fcd_sel_e;

	typedef logic [1:0] fcd_chan_t;
endpackage : fcd_pkg

/* File: logic/fcd_dma_ctrl.sv */
// Four-channel DMA controller: register port slave, arbiter and bus master sequencer
//
// How it works
// RQ1: Four channels, each with a 16-bit address and 16-bit count register.
// RQ2: One block covers up to 16,384 transfers with no processor help.
// RQ3: Count field holds cycles minus one; terminal flag marks the last cycle.
// RQ4: Count zero raises the terminal flag on the channel's first cycle.
// RQ5: Count bits 15:14 pick verify, write, read; code 11 illegal.
// RQ6: Operation bits never change during transfers; software rewrites them between blocks.
// RQ7: Verify takes the bus and grants, but drives no read/write strobes.
// RQ8: Read cycle drives memory read with I/O write.
// RQ9: Write cycle drives I/O read with memory write.
// RQ10: Request from enabled channel: take bus, then grant highest priority requester.
// RQ11: Fixed priority: channel zero highest, channel three lowest.
// RQ12: Peripheral holds request high until grant of its last wanted cycle.
// RQ13: Held request keeps the bus and runs back-to-back cycles.
// RQ14: Grant line goes low for the selected peripheral's cycle.
// RQ15: Upper address byte goes out on data pins, then data pins release.
// RQ16: Low address bits driven out on register-select lines during transfers.
// RQ17: Slave decodes four address lines; writes on I/O write, reads on I/O read.
// RQ18: Sixteen-bit registers move over the port as lower then upper byte.
// RQ19: Processor reads the status register and writes the mode register.
// RQ20: Chip select gates slave strobes and is ignored while bus master.
// RQ21: Reset clears all registers and makes every control output inactive.
// RQ22: Software loads address and count before enabling a channel.
// RQ23: Rotating mode makes the just-served channel lowest, starting with zero highest.
// RQ24: Hold request raised first; master cycles start only after hold grant.
// RQ25: Each cycle increments the address and decrements the 14-bit count.
// RQ26: Byte pointer alternates lower/upper byte; reset returns it to lower.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defines.svh"

module fcd_dma_ctrl (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic [3:0] low_addr_lines_i,
	output logic [3:0] low_addr_lines_o,
	output logic low_addr_lines_oe_n_o,
	output logic [3:0] addr_mid_o,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_n_o,
	input wire logic io_read_strobe_n_i,
	output logic io_read_strobe_n_o,
	input wire logic io_write_strobe_n_i,
	output logic io_write_strobe_n_o,
	output logic io_strobe_oe_n_o,
	output logic mem_read_strobe_n_o,
	output logic mem_write_strobe_n_o,
	output logic mem_strobe_oe_n_o,
	input wire logic [3:0] channel_request_i,
	output logic [3:0] channel_grant_n_o,
	output logic bus_hold_request_o,
	input wire logic bus_hold_grant_i,
	output logic upper_addr_latch_strobe_o,
	output logic addr_phase_enable_o,
	output logic block_end_flag_o
);
	import fcd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding shared by slave reads and writes

	function automatic fcd_sel_e fcd_decode(input logic [3:0] a);
		fcd_sel_e s;
		if (!a[`FCD_SEL_GROUP_BIT]) begin
			s = a[`FCD_SEL_REG_BIT] ? FCD_SEL_COUNT : FCD_SEL_ADDR;
		end else if (a == `FCD_REG_MODE_STATUS) begin
			s = FCD_SEL_MODE;
		end else begin
			s = FCD_SEL_NONE;
		end
		return s;
	endfunction : fcd_decode

	// Picks the requester nearest to the highest-priority channel
	function automatic logic [2:0] fcd_pick(input logic [3:0] req, input fcd_chan_t top);
		logic [2:0] r;
		fcd_chan_t c;
		r = 3'h0;
		for (int i = `FCD_NUM_CH - 1; i >= 0; i--) begin
			c = top + fcd_chan_t'(i);
			if (req[c]) begin
				r = {1'b1, c};
			end
		end
		return r;
	endfunction : fcd_pick

	////////////////////////////////////////////////////////////////////////////////
	// State

	fcd_state_e state_reg, state_next;
	fcd_chan_t chan_reg, chan_next;
	fcd_chan_t top_reg, top_next;
	// RQ1: per-channel word registers
	logic [15:0] addr_reg [`FCD_NUM_CH];
	logic [15:0] addr_next [`FCD_NUM_CH];
	logic [15:0] cnt_reg [`FCD_NUM_CH];
	logic [15:0] cnt_next [`FCD_NUM_CH];
	logic [7:0] mode_reg, mode_next;
	logic [3:0] tc_seen_reg, tc_seen_next;
	logic ptr_reg, ptr_next;
	logic rd_act_reg, rd_act_next;
	logic wr_act_reg, wr_act_next;
	logic [3:0] sel_reg, sel_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [3:0] low_addr_next, addr_mid_next, grant_n_next;
	logic [7:0] data_next;
	logic low_oe_n_next, data_oe_n_next, io_rd_n_next, io_wr_n_next, io_oe_n_next;
	logic mem_rd_n_next, mem_wr_n_next, hrq_next, upper_addr_latch_strobe_next, aen_next, tc_next;
	logic [3:0] enabled_req;
	logic [2:0] win;
	logic slave_ok, master_on, commit_rd, commit_wr, last;
	fcd_sel_e sel_kind;
	fcd_chan_t sel_ch;
	logic [1:0] op;
	logic [7:0] rbyte;
	logic [15:0] word;

	always_comb begin
		state_next = state_reg;
		chan_next = chan_reg;
		top_next = top_reg;
		addr_next = addr_reg;
		cnt_next = cnt_reg;
		mode_next = mode_reg;
		tc_seen_next = tc_seen_reg;
		ptr_next = ptr_reg;
		win = 3'h0;
		last = 1'b0;
		rbyte = `FCD_BYTE_ZERO;
		// RQ20: chip select ignored while master
		master_on = (state_reg == FCD_ST_ADDR) || (state_reg == FCD_ST_XFER) ||
			(state_reg == FCD_ST_END);
		slave_ok = !cs_n_i && !master_on;
		rd_act_next = slave_ok && !io_read_strobe_n_i;
		wr_act_next = slave_ok && !io_write_strobe_n_i;
		sel_next = (rd_act_next || wr_act_next) ? low_addr_lines_i : sel_reg;
		wdata_next = wr_act_next ? data_i : wdata_reg;
		// Commit on the strobe's rising edge, so write data has settled
		commit_rd = rd_act_reg && !rd_act_next;
		commit_wr = wr_act_reg && !wr_act_next;
		// RQ17: register select decode
		sel_kind = fcd_decode(sel_reg);
		sel_ch = sel_reg[`FCD_SEL_CH_MSB:`FCD_SEL_CH_LSB];
		word = (sel_kind == FCD_SEL_COUNT) ? cnt_reg[sel_ch] : addr_reg[sel_ch];
		// RQ19: status read returns terminal flags and bus request
		if (sel_kind == FCD_SEL_MODE) begin
			rbyte = {3'h0, bus_hold_request_o, tc_seen_reg};
		end else if (sel_kind != FCD_SEL_NONE) begin
			// RQ18: lower byte first
			rbyte = ptr_reg ? word[15:8] : word[7:0];
		end
		if (commit_wr) begin
			if (sel_kind == FCD_SEL_ADDR || sel_kind == FCD_SEL_COUNT) begin
				// RQ18: byte written by pointer
				word = ptr_reg ? {wdata_reg, word[7:0]} : {word[15:8], wdata_reg};
				if (sel_kind == FCD_SEL_COUNT) begin
					cnt_next[sel_ch] = word;
				end else begin
					addr_next[sel_ch] = word;
				end
				// RQ26: pointer alternates
				ptr_next = !ptr_reg;
			end else if (sel_kind == FCD_SEL_MODE) begin
				// RQ19: mode write; also realigns byte pointer
				mode_next = wdata_reg;
				ptr_next = 1'b0;
			end
		end else if (commit_rd && (sel_kind == FCD_SEL_ADDR || sel_kind == FCD_SEL_COUNT)) begin
			ptr_next = !ptr_reg;
		end
		enabled_req = channel_request_i & mode_next[3:0];
		case (state_reg)
			FCD_ST_IDLE: begin
				// RQ24: ask for the bus first
				if (|enabled_req) begin
					state_next = FCD_ST_HOLD;
				end
			end
			FCD_ST_HOLD: begin
				// RQ10: arbitrate only once the bus is ours
				if (bus_hold_grant_i) begin
					// RQ11: fixed mode keeps channel zero on top
					win = fcd_pick(enabled_req, top_reg);
					if (win[2]) begin
						chan_next = win[1:0];
						state_next = FCD_ST_ADDR;
					end else begin
						state_next = FCD_ST_IDLE;
					end
				end
			end
			FCD_ST_ADDR: state_next = FCD_ST_XFER;
			FCD_ST_XFER: state_next = FCD_ST_END;
			FCD_ST_END: begin
				// RQ25 RQ2: address up, 14-bit count down; RQ6 keeps bits 15:14
				addr_next[chan_reg] = addr_reg[chan_reg] + `FCD_ADDR_STEP;
				cnt_next[chan_reg][`FCD_CNT_MSB:0] =
					cnt_reg[chan_reg][`FCD_CNT_MSB:0] - `FCD_CNT_STEP;
				// RQ3: last cycle when the field reached zero
				last = cnt_reg[chan_reg][`FCD_CNT_MSB:0] == `FCD_CNT_ZERO;
				if (last) begin
					tc_seen_next[chan_reg] = 1'b1;
					if (mode_reg[`FCD_MODE_TC_STOP]) begin
						mode_next[chan_reg] = 1'b0;
					end
				end
				// RQ23: served channel drops to lowest
				top_next = mode_reg[`FCD_MODE_ROTATE] ? chan_reg + `FCD_CH_STEP : `FCD_CH_ZERO;
				enabled_req = channel_request_i & mode_next[3:0];
				// RQ13: keep the bus for a held request
				win = fcd_pick(enabled_req, top_next);
				if (bus_hold_grant_i && win[2]) begin
					chan_next = win[1:0];
					state_next = FCD_ST_ADDR;
				end else begin
					state_next = FCD_ST_IDLE;
				end
			end
			default: state_next = FCD_ST_IDLE;
		endcase
		// Status read clears terminal flags; a flag set in the same cycle survives
		if (commit_rd && sel_kind == FCD_SEL_MODE) begin
			tc_seen_next = last ? (4'h1 << chan_reg) : `FCD_STATUS_RESET;
		end
		// Registered pin values follow the next state
		hrq_next = state_next != FCD_ST_IDLE;
		aen_next = (state_next == FCD_ST_ADDR) || (state_next == FCD_ST_XFER) ||
			(state_next == FCD_ST_END);
		// RQ14: active-low grant for the selected channel
		grant_n_next = aen_next ? ~(4'h1 << chan_next) : `FCD_GRANT_IDLE;
		upper_addr_latch_strobe_next = state_next == FCD_ST_ADDR;
		// RQ16: low address out on select lines while master
		low_addr_next = addr_next[chan_next][3:0];
		addr_mid_next = aen_next ? addr_next[chan_next][7:4] : `FCD_NIB_ZERO;
		low_oe_n_next = !aen_next;
		// RQ15: upper byte only in the address phase, released afterwards
		if (state_next == FCD_ST_ADDR) begin
			data_next = addr_next[chan_next][15:8];
			data_oe_n_next = 1'b0;
		end else begin
			data_next = rbyte;
			data_oe_n_next = !(rd_act_next && rd_act_reg);
		end
		// RQ4: zero count flags the very first cycle
		tc_next = aen_next && (cnt_next[chan_next][`FCD_CNT_MSB:0] == `FCD_CNT_ZERO);
		// RQ5: operation code select
		op = cnt_next[chan_next][`FCD_OP_MSB:`FCD_OP_LSB];
		// RQ7: verify and the illegal code drive no strobes
		// RQ8: read cycle strobes
		mem_rd_n_next = !(state_next == FCD_ST_XFER && op == `FCD_OP_READ);
		io_wr_n_next = !(op == `FCD_OP_READ && (state_next == FCD_ST_XFER ||
			(state_next == FCD_ST_ADDR && mode_reg[`FCD_MODE_EXT_WRITE])));
		// RQ9: write cycle strobes; extended write starts one cycle early
		io_rd_n_next = !(state_next == FCD_ST_XFER && op == `FCD_OP_WRITE);
		mem_wr_n_next = !(op == `FCD_OP_WRITE && (state_next == FCD_ST_XFER ||
			(state_next == FCD_ST_ADDR && mode_reg[`FCD_MODE_EXT_WRITE])));
		io_oe_n_next = !aen_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge sys_clk_i) begin
		// RQ21: reset clears registers and idles every control output
		if (sys_rst_i) begin
			state_reg <= FCD_ST_IDLE;
			chan_reg <= `FCD_CH_ZERO;
			top_reg <= `FCD_CH_ZERO;
			mode_reg <= `FCD_MODE_RESET;
			tc_seen_reg <= `FCD_STATUS_RESET;
			// RQ26: pointer back to lower byte
			ptr_reg <= 1'b0;
			rd_act_reg <= 1'b0;
			wr_act_reg <= 1'b0;
			sel_reg <= `FCD_NIB_ZERO;
			wdata_reg <= `FCD_BYTE_ZERO;
			low_addr_lines_o <= `FCD_NIB_ZERO;
			low_addr_lines_oe_n_o <= 1'b1;
			addr_mid_o <= `FCD_NIB_ZERO;
			data_o <= `FCD_BYTE_ZERO;
			data_oe_n_o <= 1'b1;
			io_read_strobe_n_o <= 1'b1;
			io_write_strobe_n_o <= 1'b1;
			io_strobe_oe_n_o <= 1'b1;
			mem_read_strobe_n_o <= 1'b1;
			mem_write_strobe_n_o <= 1'b1;
			mem_strobe_oe_n_o <= 1'b1;
			channel_grant_n_o <= `FCD_GRANT_IDLE;
			bus_hold_request_o <= 1'b0;
			upper_addr_latch_strobe_o <= 1'b0;
			addr_phase_enable_o <= 1'b0;
			block_end_flag_o <= 1'b0;
			for (int i = 0; i < `FCD_NUM_CH; i++) begin
				addr_reg[i] <= `FCD_WORD_RESET;
				cnt_reg[i] <= `FCD_WORD_RESET;
			end
		end else begin
			state_reg <= state_next;
			chan_reg <= chan_next;
			top_reg <= top_next;
			mode_reg <= mode_next;
			tc_seen_reg <= tc_seen_next;
			ptr_reg <= ptr_next;
			rd_act_reg <= rd_act_next;
			wr_act_reg <= wr_act_next;
			sel_reg <= sel_next;
			wdata_reg <= wdata_next;
			low_addr_lines_o <= low_addr_next;
			low_addr_lines_oe_n_o <= low_oe_n_next;
			addr_mid_o <= addr_mid_next;
			data_o <= data_next;
			data_oe_n_o <= data_oe_n_next;
			io_read_strobe_n_o <= io_rd_n_next;
			io_write_strobe_n_o <= io_wr_n_next;
			io_strobe_oe_n_o <= io_oe_n_next;
			mem_read_strobe_n_o <= mem_rd_n_next;
			mem_write_strobe_n_o <= mem_wr_n_next;
			mem_strobe_oe_n_o <= io_oe_n_next;
			channel_grant_n_o <= grant_n_next;
			bus_hold_request_o <= hrq_next;
			upper_addr_latch_strobe_o <= upper_addr_latch_strobe_next;
			addr_phase_enable_o <= aen_next;
			block_end_flag_o <= tc_next;
			for (int i = 0; i < `FCD_NUM_CH; i++) begin
				addr_reg[i] <= addr_next[i];
				cnt_reg[i] <= cnt_next[i];
			end
		end
	end
endmodule : fcd_dma_ctrl
`default_nettype wire

/* File: sim/fcd_dma_ctrl_properties.sv */
// Checker of master sequencing, strobe pairing and reset state of the DMA controller
`timescale 1ns/1ps
`default_nettype none
module fcd_dma_ctrl_properties (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic bus_hold_grant_i,
	input wire logic [3:0] channel_grant_n_o,
	input wire logic bus_hold_request_o,
	input wire logic addr_phase_enable_o,
	input wire logic upper_addr_latch_strobe_o,
	input wire logic data_oe_n_o,
	input wire logic low_addr_lines_oe_n_o,
	input wire logic mem_read_strobe_n_o,
	input wire logic mem_write_strobe_n_o,
	input wire logic io_read_strobe_n_o,
	input wire logic io_write_strobe_n_o,
	input wire logic io_strobe_oe_n_o,
	input wire logic mem_strobe_oe_n_o,
	input wire logic block_end_flag_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////////////////////
	sequence addr_phase_s;
		upper_addr_latch_strobe_o && !data_oe_n_o && !low_addr_lines_oe_n_o;
	endsequence
	// Data pins must be free again once the latch has taken the upper byte
	sequence xfer_phase_s;
		addr_phase_enable_o && !upper_addr_latch_strobe_o && data_oe_n_o
			&& $stable(channel_grant_n_o);
	endsequence
	sequence end_phase_s;
		addr_phase_enable_o && mem_read_strobe_n_o && mem_write_strobe_n_o
			&& io_read_strobe_n_o && io_write_strobe_n_o && $stable(channel_grant_n_o);
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	transfer_shape_a: assert property (addr_phase_s |=> xfer_phase_s ##1 end_phase_s)
		else $error("transfer phases out of order");
	hold_first_a: assert property ($rose(addr_phase_enable_o) |->
		$past(bus_hold_grant_i) && bus_hold_request_o)
		else $error("master cycle without hold grant");
	grant_idle_a: assert property (!addr_phase_enable_o |-> channel_grant_n_o == 4'hf)
		else $error("grant active outside master cycle");
	grant_single_a: assert property (addr_phase_enable_o |-> $onehot(~channel_grant_n_o))
		else $error("not exactly one grant");
	read_pair_a: assert property (!mem_read_strobe_n_o |->
		!io_write_strobe_n_o && io_read_strobe_n_o && !io_strobe_oe_n_o)
		else $error("memory read without io write");
	write_pair_a: assert property (!io_read_strobe_n_o && !io_strobe_oe_n_o |->
		!mem_write_strobe_n_o && mem_read_strobe_n_o)
		else $error("io read without memory write");
	addr_drive_a: assert property (addr_phase_enable_o |-> !low_addr_lines_oe_n_o)
		else $error("address lines not driven as master");
	flag_master_a: assert property (block_end_flag_o |-> addr_phase_enable_o)
		else $error("terminal flag outside transfer");
	strobe_enable_a: assert property (mem_strobe_oe_n_o == io_strobe_oe_n_o
		&& mem_strobe_oe_n_o == !addr_phase_enable_o)
		else $error("strobe enables out of step with master");
	reset_idle_a: assert property ($fell(sys_rst_i) |-> channel_grant_n_o == 4'hf
		&& !bus_hold_request_o && !addr_phase_enable_o && !block_end_flag_o)
		else $error("outputs active after reset");
endmodule : fcd_dma_ctrl_properties

bind fcd_dma_ctrl fcd_dma_ctrl_properties fcd_dma_ctrl_properties_inst (.sys_clk_i, .sys_rst_i,
	.bus_hold_grant_i, .channel_grant_n_o, .bus_hold_request_o, .addr_phase_enable_o,
	.upper_addr_latch_strobe_o, .data_oe_n_o, .low_addr_lines_oe_n_o, .mem_read_strobe_n_o,
	.mem_write_strobe_n_o, .io_read_strobe_n_o, .io_write_strobe_n_o, .io_strobe_oe_n_o,
	.mem_strobe_oe_n_o, .block_end_flag_o);
`default_nettype wire

/* File: sim/fcd_far_model.sv */
// Host hold handshake and requesting peripherals facing the DMA controller
`timescale 1ns/1ps
`default_nettype none
module fcd_far_model (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic bus_hold_request_i,
	input wire logic [3:0] channel_grant_n_i,
	input wire logic upper_addr_latch_strobe_i,
	input wire logic slow_i,
	input wire logic [3:0] load_i,
	input wire logic [7:0] want_i,
	output logic bus_hold_grant_o,
	output logic [3:0] channel_request_o
);
	logic [3:0][7:0] left_reg = '0;
	logic [1:0] wait_reg = 2'h0;
	logic grant_reg = 1'b0;
	always @(posedge sys_clk_i) begin
		if (sys_rst_i || !bus_hold_request_i) begin
			wait_reg <= 2'h0;
			grant_reg <= 1'b0;
		end else if (slow_i && wait_reg != 2'h3)
			wait_reg <= wait_reg + 2'h1;
		else
			grant_reg <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			if (sys_rst_i)
				left_reg[c] <= 8'h00;
			else if (load_i[c])
				left_reg[c] <= want_i;
			// request held until last wanted grant
			else if (upper_addr_latch_strobe_i && !channel_grant_n_i[c])
				left_reg[c] <= left_reg[c] - 8'h01;
		end
	end
	assign bus_hold_grant_o = grant_reg;
	always_comb begin
		for (int c = 0; c < 4; c++)
			channel_request_o[c] = left_reg[c] != 8'h00;
	end
endmodule : fcd_far_model
`default_nettype wire

/* File: sim/fcd_dma_ctrl_test.sv */
// Self-checking bench: register port, transfer types, terminal flag and priority
`timescale 1ns/1ps
`default_nettype none
module fcd_dma_ctrl_test;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1, cs_n_i = 1'b1, io_read_strobe_n_i = 1'b1, io_write_strobe_n_i = 1'b1;
	logic [3:0] low_addr_lines_i = 4'h0, low_addr_lines_o, addr_mid_o, channel_grant_n_o;
	logic [3:0] channel_request_i, seen = 4'h0, load = 4'h0;
	logic [7:0] data_i = 8'h00, data_o, want = 8'h00, b;
	logic bus_hold_grant_i, io_read_strobe_n_o, io_write_strobe_n_o, mem_read_strobe_n_o;
	logic mem_write_strobe_n_o, bus_hold_request_o, upper_addr_latch_strobe_o;
	logic addr_phase_enable_o, block_end_flag_o, slow = 1'b0, chk = 1'b0;
	int fails = 0, n_compared = 0, n_xfer = 0, tc_at = 0;
	logic [3:0] order [$];
	fcd_dma_ctrl fcd_dma_ctrl_inst (.sys_clk_i, .sys_rst_i, .cs_n_i, .low_addr_lines_i,
		.low_addr_lines_o, .low_addr_lines_oe_n_o(), .addr_mid_o, .data_i, .data_o,
		.data_oe_n_o(), .io_read_strobe_n_i, .io_read_strobe_n_o, .io_write_strobe_n_i,
		.io_write_strobe_n_o, .io_strobe_oe_n_o(), .mem_read_strobe_n_o, .mem_write_strobe_n_o,
		.mem_strobe_oe_n_o(), .channel_request_i, .channel_grant_n_o, .bus_hold_request_o,
		.bus_hold_grant_i, .upper_addr_latch_strobe_o, .addr_phase_enable_o, .block_end_flag_o);
	fcd_far_model fcd_far_model_inst (.sys_clk_i, .sys_rst_i,
		.bus_hold_request_i(bus_hold_request_o), .channel_grant_n_i(channel_grant_n_o),
		.upper_addr_latch_strobe_i(upper_addr_latch_strobe_o), .slow_i(slow), .load_i(load),
		.want_i(want), .bus_hold_grant_o(bus_hold_grant_i), .channel_request_o(channel_request_i));
	initial begin
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1 {cs_n_i, io_write_strobe_n_i, low_addr_lines_i, data_i} = {2'b00, a, d};
		@(posedge sys_clk_i);
		#1 {cs_n_i, io_write_strobe_n_i} = 2'b11;
		@(posedge sys_clk_i);
	endtask : wr
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a, v[15:8]);
	endtask : wr16
	// Strobe held until read data has stood for a full cycle
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk_i);
		#1 {cs_n_i, io_read_strobe_n_i, low_addr_lines_i} = {2'b00, a};
		repeat (3) @(posedge sys_clk_i);
		b = data_o;
		#1 {cs_n_i, io_read_strobe_n_i} = 2'b11;
		@(posedge sys_clk_i);
	endtask : rd
	task automatic run(input logic [3:0] m, input logic [7:0] n, input logic s);
		int k;
		{load, want, slow} = {m, n, s};
		@(posedge sys_clk_i);
		#1 load = 4'h0;
		k = 0;
		do begin
			@(posedge sys_clk_i);
			k++;
		end while ((bus_hold_request_o || |channel_request_i) && k < 300);
		cmp(16'(k < 300), 16'h1);
		repeat (2) @(posedge sys_clk_i);
		#1 chk = 1'b0;
	endtask : run
	// Watches each transfer as it goes by
	always @(posedge sys_clk_i) begin
		seen <= seen | ~{mem_read_strobe_n_o, mem_write_strobe_n_o, io_read_strobe_n_o,
			io_write_strobe_n_o};
		if (block_end_flag_o)
			tc_at <= n_xfer + 32'(upper_addr_latch_strobe_o);
		if (upper_addr_latch_strobe_o) begin
			n_xfer <= n_xfer + 1;
			order.push_back(channel_grant_n_o);
			if (chk)
				cmp({data_o, addr_mid_o, low_addr_lines_o}, 16'h12f0 + 16'(n_xfer));
		end
	end
	initial begin
		#100000;
		fails++;
		final_report();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		rd(4'h8);
		cmp(b, 8'h00);
		rd(4'h9);
		cmp(b, 8'h00);
		wr16(4'h2, 16'h12fe);
		rd(4'h2);
		cmp(b, 8'hfe);
		rd(4'h2);
		cmp(b, 8'h12);
		wr(4'h2, 8'h34);
		wr(4'h8, 8'h00);
		rd(4'h2);
		cmp(b, 8'h34);
		rd(4'h2);
		$display("register port test done");
		for (int op = 0; op < 4; op++) begin
			// Channel set up before it is enabled
			wr16(4'h0, 16'h12f0);
			wr16(4'h1, {2'(op), 13'h0, op[0]});
			wr(4'h8, 8'h01);
			#1 {seen, n_xfer, tc_at, chk} = {4'h0, 32'h0, 32'h0, 1'b1};
			run(4'h1, 8'(op[0] + 1), op[1]);
			cmp(16'(n_xfer), 16'(op[0] + 1));
			cmp(16'(tc_at), 16'(op[0] + 1));
			cmp(seen, 4'(16'h0960 >> (op * 4)));
			rd(4'h8);
			cmp(b, 8'h01);
			rd(4'h0);
			cmp(b, 8'hf0 + 8'(op[0] + 1));
			rd(4'h1);
			cmp(b & 8'hc0, {2'(op), 6'h0});
		end
		$display("transfer type test done");
		// Terminal stop disables the channel, so a request still standing is not served
		wr16(4'h1, 16'h4000);
		wr(4'h8, 8'h41);
		#1 {n_xfer, want, load} = {32'h0, 8'h2, 4'h1};
		@(posedge sys_clk_i);
		#1 load = 4'h0;
		repeat (30) @(posedge sys_clk_i);
		cmp(16'(n_xfer), 16'h1);
		cmp(16'(bus_hold_request_o), 16'h0);
		#1 {want, load} = {8'h00, 4'h1};
		@(posedge sys_clk_i);
		#1 load = 4'h0;
		$display("terminal stop test done");
		for (int r = 0; r < 2; r++) begin
			wr16(4'h0, 16'h0100);
			wr16(4'h1, 16'h8010);
			wr16(4'h2, 16'h0200);
			wr16(4'h3, 16'h8010);
			wr(4'h8, {3'h0, r[0], 4'h3});
			#1 order.delete();
			run(4'h3, 8'h2, 1'b0);
			cmp(16'(order.size()), 16'h4);
			for (int i = 0; i < 4; i++)
				cmp(order[i], ((r == 1) ? i[0] : i[1]) ? 4'hd : 4'he);
		end
		$display("priority test done");
		final_report();
	end
endmodule : fcd_dma_ctrl_test
`default_nettype wire
